// File: core/tgc_map.svh
// Register offsets, field positions, reset values and codes of the timer gate control block.
`ifndef TGC_MAP_SVH
`define TGC_MAP_SVH

// ==========================================================================
// Register map (AXI4-Lite byte addresses)
// ==========================================================================
`define TGC_GATE_CONTROL_OFFSET 12'h000
`define TGC_TIMER_CONTROL_OFFSET 12'h004
`define TGC_COUNT_OFFSET 12'h008

// ==========================================================================
// Gate control fields
// ==========================================================================
`define TGC_BIT_ENABLE 7
`define TGC_BIT_POLARITY 6
`define TGC_BIT_TOGGLE 5
`define TGC_BIT_SINGLE 4
`define TGC_BIT_GO_DONE 3
`define TGC_BIT_VALUE 2
`define TGC_GATE_CONTROL_RESET 8'h00
`define TGC_SRC_PIN 2'h0
`define TGC_SRC_OVERFLOW 2'h1

// ==========================================================================
// Timer control fields
// ==========================================================================
`define TGC_BIT_TIMER_ON 0

// ==========================================================================
// Bus answers
// ==========================================================================
`define TGC_RESP_OKAY 2'h0
`define TGC_RESP_SLVERR 2'h2

`endif

// File: core/tgc_pkg.sv
// Types shared by the timer gate control block.
package tgc_pkg;
  // Software-held fields of the gate control register.
  typedef struct packed {
    logic       enable;
    logic       polarity;
    logic       toggle;
    logic       single;
    logic       go_done;
    logic [1:0] source;
  } tgc_gate_cfg_t;

  // Gate state seen by the timer.
  typedef struct packed {
    logic value;
    logic count_enable;
  } tgc_gate_stat_t;
endpackage

// File: core/tgc_timer_gate.sv
// Timer gate control with AXI4-Lite register access and a 16-bit gated counter.
//
// Contract
// - Gate enable ignored while timer is off.
// - Both set: count only when gate allows.
// - Single-pulse bit selects single-pulse gate mode.
// - Eight-bit register layout, cleared on reset.
// - Source 00 pin, 01 other overflow.
// - Value bit shows gate, ignores enable.
// - Go/done armed by software, cleared by hardware.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`include "tgc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tgc_timer_gate
  import tgc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        gate_pin,
  input  wire logic        other_timer_overflow,
  output logic             timer_count_enable,
  output logic             timer_overflow
);

  // ========================================================================
  // Storage
  // ========================================================================
  tgc_gate_cfg_t  cfg_q;          // Writable gate control fields.
  tgc_gate_stat_t stat_q;         // Registered gate value and count enable.
  logic           timer_on_q;     // Timer-on bit.
  logic [15:0]    count_q;        // Timer count.
  logic           overflow_q;     // Overflow pulse.
  logic [1:0]     pin_sync_q;     // Pin synchroniser; bit 0 is the first stage.
  logic           source_prev_q;  // Previous selected source, for edge detection.
  logic           toggle_ff_q;    // Toggle flip-flop.
  logic           single_ff_q;    // Single-pulse window flip-flop.
  logic           value_prev_q;   // Previous gate value, for completion detection.
  logic           aw_held_q;      // Write address captured.
  logic           w_held_q;       // Write data captured.
  logic [11:0]    awaddr_q;       // Captured write address.
  logic [31:0]    wdata_q;        // Captured write data.
  logic [3:0]     wstrb_q;        // Captured byte enables.
  logic           bvalid_q;       // Write answer pending.
  logic [1:0]     bresp_q;        // Write answer code.
  logic           rvalid_q;       // Read answer pending.
  logic [31:0]    rdata_q;        // Read data.
  logic [1:0]     rresp_q;        // Read answer code.

  // ========================================================================
  // Gate source and gate function
  // ========================================================================
  // Only the second synchroniser stage and the on-chip overflow reach the logic.
  wire logic source_raw = (cfg_q.source == `TGC_SRC_PIN)      ? pin_sync_q[1] :
                          (cfg_q.source == `TGC_SRC_OVERFLOW) ? other_timer_overflow :
                          1'b0;
  // Polarity folds active-low gates into active-high.
  wire logic source_act = cfg_q.polarity ? source_raw : ~source_raw;
  wire logic source_rise = source_act & ~source_prev_q;
  // Toggle mode replaces the level with the toggle flip-flop.
  wire logic after_toggle = cfg_q.toggle ? toggle_ff_q : source_act;
  // Single-pulse mode lets through one active phase after arming.
  wire logic gate_value = cfg_q.single ? (single_ff_q & after_toggle) : after_toggle;
  // Disabled gate or stopped timer: the enable bit carries no weight when off.
  wire logic count_en = timer_on_q & (~cfg_q.enable | gate_value);

  // ========================================================================
  // Bus decode
  // ========================================================================
  // Word hit: compares the word index only, so byte lanes within a word alias.
  function automatic logic word_hit(input logic [11:0] addr, input logic [11:0] offset);
    return addr[11:2] == offset[11:2];
  endfunction
  // Reset image of the register, split so the read-only value bit is left out.
  localparam logic [7:0] GATE_RESET = `TGC_GATE_CONTROL_RESET;
  wire logic wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire logic wr_gate = wr_fire & word_hit(awaddr_q, `TGC_GATE_CONTROL_OFFSET);
  wire logic wr_tctl = wr_fire & word_hit(awaddr_q, `TGC_TIMER_CONTROL_OFFSET);
  wire logic wr_cnt  = wr_fire & word_hit(awaddr_q, `TGC_COUNT_OFFSET);
  wire logic wr_ok   = wr_gate | wr_tctl | wr_cnt;
  wire logic [7:0] gate_rd = {cfg_q.enable, cfg_q.polarity, cfg_q.toggle, cfg_q.single,
                              cfg_q.go_done, stat_q.value, cfg_q.source};
  wire logic rd_gate = word_hit(s_axi_araddr, `TGC_GATE_CONTROL_OFFSET);
  wire logic rd_tctl = word_hit(s_axi_araddr, `TGC_TIMER_CONTROL_OFFSET);
  wire logic rd_cnt  = word_hit(s_axi_araddr, `TGC_COUNT_OFFSET);
  wire logic [31:0] rd_word = rd_gate ? {24'h000000, gate_rd} :
                              rd_tctl ? {31'h00000000, timer_on_q} :
                              rd_cnt  ? {16'h0000, count_q} : 32'h00000000;
  wire logic rd_ok = rd_gate | rd_tctl | rd_cnt;
  // Acquisition completes when the passed gate phase ends.
  wire logic acq_done = cfg_q.single & single_ff_q & value_prev_q & ~gate_value;
  wire logic sw_go = wr_gate & wstrb_q[0] & wdata_q[`TGC_BIT_GO_DONE];

  assign s_axi_awready = ~aw_held_q;
  assign s_axi_wready  = ~w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign timer_count_enable = stat_q.count_enable;
  assign timer_overflow     = overflow_q;

  // ========================================================================
  // Write channel: address and data taken in either order.
  // ========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `TGC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // Unmapped writes are answered with an error and change nothing.
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        // Address and data slots reopen only once the answer is taken.
        bvalid_q  <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Read channel: one read at a time, answered the cycle after it is taken.
  // ========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `TGC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_ok ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ========================================================================
  // Control registers
  // ========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q      <= tgc_gate_cfg_t'({GATE_RESET[7:3], GATE_RESET[1:0]});
      timer_on_q <= 1'b0;
    end else begin
      if (wr_gate && wstrb_q[0]) begin
        cfg_q.enable   <= wdata_q[`TGC_BIT_ENABLE];
        cfg_q.polarity <= wdata_q[`TGC_BIT_POLARITY];
        cfg_q.toggle   <= wdata_q[`TGC_BIT_TOGGLE];
        cfg_q.single   <= wdata_q[`TGC_BIT_SINGLE];
        cfg_q.source   <= wdata_q[1:0];
      end
      // Software may only set go/done; a fresh go wins over a completion.
      if (sw_go) begin
        cfg_q.go_done <= 1'b1;
      end else if (acq_done || !cfg_q.single) begin
        cfg_q.go_done <= 1'b0;
      end
      if (wr_tctl && wstrb_q[0]) begin
        timer_on_q <= wdata_q[`TGC_BIT_TIMER_ON];
      end
    end
  end

  // ========================================================================
  // Gate flip-flops and synchroniser
  // ========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_q    <= 2'h0;
      source_prev_q <= 1'b0;
      toggle_ff_q   <= 1'b0;
      single_ff_q   <= 1'b0;
      value_prev_q  <= 1'b0;
      stat_q        <= '0;
    end else begin
      pin_sync_q    <= {pin_sync_q[0], gate_pin};
      source_prev_q <= source_act;
      value_prev_q  <= gate_value;
      // Clearing toggle mode, or stopping the timer, clears the flip-flop.
      if (!cfg_q.toggle || !timer_on_q) begin
        toggle_ff_q <= 1'b0;
      end else if (source_rise) begin
        toggle_ff_q <= ~toggle_ff_q;
      end
      // The window opens on the first active edge while armed.
      if (!cfg_q.go_done) begin
        single_ff_q <= 1'b0;
      end else if (source_rise) begin
        single_ff_q <= 1'b1;
      end
      stat_q.value        <= gate_value;
      stat_q.count_enable <= count_en;
    end
  end

  // ========================================================================
  // Counter, incremented while the gate allows.
  // ========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q    <= 16'h0000;
      overflow_q <= 1'b0;
    end else if (wr_cnt) begin
      count_q    <= wdata_q[15:0];
      overflow_q <= 1'b0;
    end else begin
      overflow_q <= stat_q.count_enable & (count_q == 16'hffff);
      if (stat_q.count_enable) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// File: verification/tgc_checker.sv
// Port-level checks of the timer gate control block.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker
// ==========================================================================
module tgc_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_overflow
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until taken, so software never loses one.
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write answer dropped.");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read answer dropped.");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while answer pending.");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write answer late.");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late.");
  a_b_released: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write answer repeated.");
  a_wrap_pulse: assert property (timer_overflow |=> !timer_overflow)
    else $error("Overflow longer than a cycle.");
  // Reset must silence both answers and the wrap pulse.
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !timer_overflow)
    else $error("Outputs busy after reset.");
endmodule
bind tgc_timer_gate tgc_checker u_chk (.*);
`default_nettype wire

// File: verification/tgc_timer_gate_tb.sv
// Self-checking bench of the timer gate control block.
`include "tgc_map.svh"
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench
// ==========================================================================
module tgc_timer_gate_tb;
  localparam logic [11:0] GC = `TGC_GATE_CONTROL_OFFSET;
  logic        aclk = 1'b0, aresetn = 1'b0, gate_pin = 1'b0, other_timer_overflow = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'h1;
  // Answer readies start high; the master lowers them only for the slow answer taker check.
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, wrapped, aw_ok, w_ok;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        timer_count_enable, timer_overflow;
  int          mismatches = 0, tests_run = 0;
  tgc_timer_gate u_dut (.*);
  always #5 aclk = ~aclk;
  // Compare one value and count the outcome.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Offer address and data together; release each once it is taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // Gate waits cover the pin synchroniser and the registered enable.
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    wt(16);
    aresetn <= 1'b1;
    wt(1);
    rd_reg(GC);
    chk("gate ctl reset", rd & 32'hfb, 32'h0);
    wr(GC, 32'he1);
    chk("write okay", rsp, `TGC_RESP_OKAY);
    rd_reg(GC);
    chk("read okay", rsp, `TGC_RESP_OKAY);
    chk("gate ctl fields", rd & 32'hfb, 32'he1);
    wr(GC, 32'h80);
    wt(6);
    chk("timer off", timer_count_enable, 1'b0);
    wr(`TGC_TIMER_CONTROL_OFFSET, 32'h1);
    wt(6);
    chk("low gate counts", timer_count_enable, 1'b1);
    gate_pin <= 1'b1;
    wt(6);
    chk("high gate stops", timer_count_enable, 1'b0);
    wr(GC, 32'hc0);
    wt(6);
    chk("active high", timer_count_enable, 1'b1);
    wr(GC, 32'h40);
    rd_reg(GC);
    chk("value no enable", rd[2], 1'b1);
    chk("enable off runs", timer_count_enable, 1'b1);
    wr(GC, 32'hc1);
    wt(6);
    chk("overflow src low", timer_count_enable, 1'b0);
    other_timer_overflow <= 1'b1;
    wt(6);
    chk("overflow src high", timer_count_enable, 1'b1);
    wr(GC, 32'hc2);
    wt(6);
    chk("reserved src", timer_count_enable, 1'b0);
    other_timer_overflow <= 1'b0;
    gate_pin <= 1'b0;
    wr(GC, 32'he0);
    // Each full pin pulse flips the toggle gate once.
    for (int i = 0; i < 2; i++) begin
      gate_pin <= 1'b1;
      wt(4);
      gate_pin <= 1'b0;
      wt(6);
      chk("toggle gate", timer_count_enable, (i == 0));
    end
    wr(GC, 32'hd8);
    rd_reg(GC);
    chk("armed", rd[3], 1'b1);
    chk("armed idle", timer_count_enable, 1'b0);
    gate_pin <= 1'b1;
    wt(7);
    chk("pulse counts", timer_count_enable, 1'b1);
    gate_pin <= 1'b0;
    wt(6);
    rd_reg(GC);
    chk("done", rd[3], 1'b0);
    rd_reg(`TGC_COUNT_OFFSET);
    s_axi_wdata <= rd;
    gate_pin <= 1'b1;
    wt(8);
    gate_pin <= 1'b0;
    rd_reg(`TGC_COUNT_OFFSET);
    chk("one pulse only", rd, s_axi_wdata);
    rd_reg(12'h010);
    chk("unmapped read", rsp, `TGC_RESP_SLVERR);
    wr(12'h010, 32'hff);
    chk("unmapped write", rsp, `TGC_RESP_SLVERR);
    // Slow answer takers: the answers must stand until taken.
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    wr(GC, 32'h0);
    wt(2);
    s_axi_bready <= 1'b1;
    wt(2);
    rd_reg(GC);
    wt(2);
    s_axi_rready <= 1'b1;
    wt(2);
    chk("slow read", rd & 32'hfb, 32'h0);
    wr(`TGC_COUNT_OFFSET, 32'hfff8);
    wrapped = 1'b0;
    repeat (40) begin
      @(posedge aclk);
      if (timer_overflow === 1'b1) wrapped = 1'b1;
    end
    chk("wrap pulse", wrapped, 1'b1);
    final_report();
  end
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    wt(20000);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
